// [hw/pid_ref_filter.sv]
// First-order low-pass stage for the PID reference, stepped once per millisecond
`timescale 1ns/1ps
`default_nettype none
module pid_ref_filter (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        tick_i,
    input  wire logic [15:0] time_ms_i,
    input  wire logic [15:0] target_i,
    output logic      [15:0] value_o
);
    pid_scaling_pkg::filt_s st_ff;
    pid_scaling_pkg::filt_s nxt;
    logic [17:0] tgt_q8;
    logic [16:0] rw;
    logic [17:0] step;

    assign tgt_q8  = {target_i[9:0], 8'h00};
    // Integer part of the Q8 state; the low byte keeps sub-step precision
    assign value_o = 16'(st_ff.y[17:8]);

    // Each millisecond y moves by (target - y) / T, so T is the time constant
    always_comb begin
        nxt  = st_ff;
        rw   = {st_ff.r, st_ff.q[17]};
        step = (st_ff.q == 18'h00000) ? 18'h00001 : st_ff.q;
        if (st_ff.busy) begin
            if (rw >= {1'b0, time_ms_i}) begin
                nxt.r = 16'(rw - {1'b0, time_ms_i});
                nxt.q = {st_ff.q[16:0], 1'b1};
            end else begin
                nxt.r = rw[15:0];
                nxt.q = {st_ff.q[16:0], 1'b0};
            end
            nxt.cnt = st_ff.cnt - 5'h01;
            if (st_ff.cnt == 5'h00) begin
                nxt.busy = 1'b0;
                step     = (nxt.q == 18'h00000) ? 18'h00001 : nxt.q;
                nxt.y    = st_ff.neg ? st_ff.y - step : st_ff.y + step;
            end
        end else if (tick_i) begin
            if (time_ms_i == 16'h0000) begin
                nxt.y = tgt_q8;
            end else if (tgt_q8 != st_ff.y) begin
                nxt.neg  = tgt_q8 < st_ff.y;
                nxt.q    = nxt.neg ? st_ff.y - tgt_q8 : tgt_q8 - st_ff.y;
                nxt.r    = 16'h0000;
                nxt.cnt  = 5'h11;
                nxt.busy = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_filter_bypass: assert property (tick_i && !st_ff.busy && time_ms_i == 16'h0000 |=>
        st_ff.y == $past(tgt_q8)) else $error("zero time constant did not pass through");
    a_filter_done: assert property ($rose(st_ff.busy) |-> ##18 !st_ff.busy)
        else $error("filter step took wrong number of cycles");
endmodule // pid_ref_filter
`default_nettype wire

// [hw/pid_scaling_pkg.sv]
// Constants, register map and state types of the PID setpoint and scaling block
package pid_scaling_pkg;
    localparam int CLK_HZ     = 250_000_000;
    localparam int MS_PER_S   = 1000;
    localparam int MS_CYCLES  = CLK_HZ / MS_PER_S;
    localparam int SAMPLE_MS  = 50;
    localparam int DO_COUNT   = 5;
    localparam int PCT_FULL   = 1000;      // 100.0 % in steps of 0.1 %
    localparam int SCALE_DIV  = 1000;
    localparam int GAIN_ONE   = 1000;      // Gains are held in thousandths
    localparam int KI_TA_MUL  = 5;         // Ki * Ta = gain * 100 * 0.05
    localparam int KD_TA_MUL  = 2000;      // Kd / Ta = gain * 100 / 0.05
    localparam int GAIN_DIV   = 1000000;

    localparam logic [7:0] OFS_FB_IND   = 8'h00;
    localparam logic [7:0] OFS_REF_IND  = 8'h04;
    localparam logic [7:0] OFS_FUNC     = 8'h08;
    localparam logic [7:0] OFS_KP       = 8'h0C;
    localparam logic [7:0] OFS_KI       = 8'h10;
    localparam logic [7:0] OFS_KD       = 8'h14;
    localparam logic [7:0] OFS_KPAD_REF = 8'h18;
    localparam logic [7:0] OFS_FILT     = 8'h1C;
    localparam logic [7:0] OFS_ACTION   = 8'h20;
    localparam logic [7:0] OFS_SCALE    = 8'h24;
    localparam logic [7:0] OFS_FMT      = 8'h28;
    localparam logic [7:0] OFS_THR      = 8'h2C;
    localparam logic [7:0] OFS_LOAD_EN  = 8'h30;
    localparam logic [7:0] OFS_SPD_REF  = 8'h34;
    localparam logic [7:0] OFS_REF_SRC  = 8'h38;
    localparam logic [7:0] OFS_DO_BASE  = 8'h40;
    localparam logic [7:0] OFS_IRQ_ST   = 8'h60;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h64;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h68;

    localparam logic [15:0] FILT_RST  = 16'h0032;
    localparam logic [15:0] SCALE_RST = 16'h03E8;
    localparam logic [1:0]  FMT_RST   = 2'h1;
    localparam logic [15:0] THR_RST   = 16'h0384;
    localparam logic [7:0]  DO_ABOVE  = 8'h16;
    localparam logic [7:0]  DO_BELOW  = 8'h17;

    localparam int IRQ_SAMPLE = 0;
    localparam int IRQ_LOAD   = 1;
    localparam int IRQ_CROSS  = 2;
    localparam int IRQ_W      = 3;

    typedef enum logic [1:0] {FS_NONE, FS_AI1, FS_AI3, FS_FREQ} fsel_e;

    typedef struct packed {
        logic [17:0] y;
        logic [17:0] q;
        logic [15:0] r;
        logic [4:0]  cnt;
        logic        busy;
        logic        neg;
    } filt_s;

    typedef struct packed {
        fsel_e                      func_sel;
        logic [15:0]                kp;
        logic [15:0]                ki;
        logic [15:0]                kd;
        logic [15:0]                kpad_ref;
        logic [15:0]                filt_ms;
        logic                       action;
        logic [15:0]                scale;
        logic [1:0]                 fmt;
        logic [15:0]                thr;
        logic                       load_en;
        logic [15:0]                spd_ref;
        logic                       ref_src;
        logic [DO_COUNT-1:0][7:0]   do_func;
        logic [DO_COUNT-1:0]        do_out;
        logic [IRQ_W-1:0]           irq_st;
        logic [IRQ_W-1:0]           irq_en;
        logic                       ack;
        logic [31:0]                rdat;
        logic [17:0]                ms_cnt;
        logic [5:0]                 smp_cnt;
        logic [16:0]                e_prev;
        logic [15:0]                pid_out;
        logic [15:0]                spd_out;
        logic [1:0]                 sync;
        logic                       auto_prev;
        logic                       above;
        logic [15:0]                fb_ind;
        logic [15:0]                ref_ind;
    } st_s;
endpackage

// [hw/pid_setpoint_feedback_scaling.sv]
// PID setpoint, feedback selection, scaling and gain block with Wishbone registers
//
// Overview of operation
// - Feedback indication scaled by factor, formatted
// - Reference indication uses same scale, format
// - Function code enables PID, picks feedback
// - Automatic keypad mode uses percent keypad setpoint
// - Manual mode uses keypad speed reference
// - Keypad setpoint kept when auto load enabled
// - Reference filtered with millisecond time constant
// - Action code zero direct, one reverse
// - Scale factor maps full feedback onto indications
// - Format code places the decimal point
// - Outputs compare feedback against percent threshold
// - Three gains held; differential defaults zero
// - Controller updates every fifty milliseconds
// - Manual to automatic copies feedback into setpoint
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pid_setpoint_feedback_scaling #(
    parameter int MS_CYCLES = pid_scaling_pkg::MS_CYCLES,
    parameter int SAMPLE_MS = pid_scaling_pkg::SAMPLE_MS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] first_analog_input_i,
    input  wire logic [15:0] third_analog_input_i,
    input  wire logic [15:0] frequency_input_i,
    input  wire logic [15:0] external_reference_i,
    input  wire logic        auto_mode_i,
    output logic             pid_enable_o,
    output logic      [15:0] pid_output_o,
    output logic      [15:0] speed_reference_o,
    output logic      [pid_scaling_pkg::DO_COUNT-1:0] digital_outputs_o,
    output logic             irq_o
);
    localparam int DN = pid_scaling_pkg::DO_COUNT;

    pid_scaling_pkg::st_s st_ff;
    pid_scaling_pkg::st_s nxt;
    logic [15:0] fb;
    logic [15:0] ref_act;
    logic [15:0] ref_filt;
    logic        req;
    logic        wr;
    logic        ms_tick;
    logic        smp_tick;
    logic        auto_mode;
    logic        load_evt;
    logic        fb_above;
    logic [pid_scaling_pkg::IRQ_W-1:0] ev;
    logic [pid_scaling_pkg::IRQ_W-1:0] clr;
    longint      e_cur;
    longint      acc;
    longint      y_new;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] pick_fb(input pid_scaling_pkg::fsel_e f,
                                            input logic [15:0] a1, input logic [15:0] a3,
                                            input logic [15:0] fi);
        case (f)
            pid_scaling_pkg::FS_AI1:  pick_fb = a1;
            pid_scaling_pkg::FS_AI3:  pick_fb = a3;
            pid_scaling_pkg::FS_FREQ: pick_fb = fi;
            default:                  pick_fb = 16'h0000;
        endcase
    endfunction

    function automatic logic compare_out(input logic [7:0] f, input logic [15:0] v,
                                         input logic [15:0] thr);
        compare_out = (f == pid_scaling_pkg::DO_ABOVE && v > thr) ||
                      (f == pid_scaling_pkg::DO_BELOW && v < thr);
    endfunction

    function automatic logic [15:0] scale_ind(input logic [15:0] v, input logic [15:0] s);
        scale_ind = 16'((32'(v) * 32'(s)) / 32'(pid_scaling_pkg::SCALE_DIV));
    endfunction

    assign fb        = pick_fb(st_ff.func_sel, first_analog_input_i,
                               third_analog_input_i, frequency_input_i);
    assign ref_act   = (st_ff.ref_src == 1'b0) ? st_ff.kpad_ref : external_reference_i;
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr        = req & wb_we_i & st_ff.ack;
    assign ms_tick   = st_ff.ms_cnt == 18'(MS_CYCLES - 1);
    assign smp_tick  = ms_tick && st_ff.smp_cnt == 6'(SAMPLE_MS - 1);
    assign auto_mode = st_ff.sync[1];
    assign load_evt  = auto_mode & ~st_ff.auto_prev & ~st_ff.ref_src & st_ff.load_en &
                       pid_enable_o;
    assign fb_above  = fb > st_ff.thr;
    assign clr       = (wr && wb_adr_i == pid_scaling_pkg::OFS_IRQ_CLR) ?
                       wb_dat_i[pid_scaling_pkg::IRQ_W-1:0] : '0;

    pid_ref_filter u_filter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (ms_tick),
        .time_ms_i (st_ff.filt_ms),
        .target_i  (ref_act),
        .value_o   (ref_filt)
    );

    always_comb begin
        nxt   = st_ff;
        e_cur = 0;
        acc   = 0;
        y_new = 0;
        ev    = '0;
        // Bus slave: ack one cycle after the request, writes land on the acked edge
        nxt.ack = req & ~st_ff.ack;
        if (req && !st_ff.ack) begin
            nxt.rdat = 32'h00000000;
            case (wb_adr_i)
                pid_scaling_pkg::OFS_FB_IND:   nxt.rdat = {14'h0000, st_ff.fmt, st_ff.fb_ind};
                pid_scaling_pkg::OFS_REF_IND:  nxt.rdat = {14'h0000, st_ff.fmt, st_ff.ref_ind};
                pid_scaling_pkg::OFS_FUNC:     nxt.rdat = 32'(st_ff.func_sel);
                pid_scaling_pkg::OFS_KP:       nxt.rdat = 32'(st_ff.kp);
                pid_scaling_pkg::OFS_KI:       nxt.rdat = 32'(st_ff.ki);
                pid_scaling_pkg::OFS_KD:       nxt.rdat = 32'(st_ff.kd);
                pid_scaling_pkg::OFS_KPAD_REF: nxt.rdat = 32'(st_ff.kpad_ref);
                pid_scaling_pkg::OFS_FILT:     nxt.rdat = 32'(st_ff.filt_ms);
                pid_scaling_pkg::OFS_ACTION:   nxt.rdat = 32'(st_ff.action);
                pid_scaling_pkg::OFS_SCALE:    nxt.rdat = 32'(st_ff.scale);
                pid_scaling_pkg::OFS_FMT:      nxt.rdat = 32'(st_ff.fmt);
                pid_scaling_pkg::OFS_THR:      nxt.rdat = 32'(st_ff.thr);
                pid_scaling_pkg::OFS_LOAD_EN:  nxt.rdat = 32'(st_ff.load_en);
                pid_scaling_pkg::OFS_SPD_REF:  nxt.rdat = 32'(st_ff.spd_ref);
                pid_scaling_pkg::OFS_REF_SRC:  nxt.rdat = 32'(st_ff.ref_src);
                pid_scaling_pkg::OFS_IRQ_ST:   nxt.rdat = 32'(st_ff.irq_st);
                pid_scaling_pkg::OFS_IRQ_EN:   nxt.rdat = 32'(st_ff.irq_en);
                default: begin
                    for (int i = 0; i < DN; i++) begin
                        if (wb_adr_i == pid_scaling_pkg::OFS_DO_BASE + 8'(4 * i)) begin
                            nxt.rdat = 32'(st_ff.do_func[i]);
                        end
                    end
                end
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                pid_scaling_pkg::OFS_FUNC: begin
                    if (wb_sel_i[0]) begin
                        nxt.func_sel = pid_scaling_pkg::fsel_e'(wb_dat_i[1:0]);
                    end
                end
                pid_scaling_pkg::OFS_KP: nxt.kp = merge(st_ff.kp, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_KI: nxt.ki = merge(st_ff.ki, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_KD: nxt.kd = merge(st_ff.kd, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_KPAD_REF: begin
                    nxt.kpad_ref = merge(st_ff.kpad_ref, wb_dat_i, wb_sel_i);
                end
                pid_scaling_pkg::OFS_FILT: nxt.filt_ms = merge(st_ff.filt_ms, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_ACTION: begin
                    if (wb_sel_i[0]) begin
                        nxt.action = wb_dat_i[0];
                    end
                end
                pid_scaling_pkg::OFS_SCALE: nxt.scale = merge(st_ff.scale, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_FMT: begin
                    if (wb_sel_i[0]) begin
                        nxt.fmt = wb_dat_i[1:0];
                    end
                end
                pid_scaling_pkg::OFS_THR: nxt.thr = merge(st_ff.thr, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_LOAD_EN: begin
                    if (wb_sel_i[0]) begin
                        nxt.load_en = wb_dat_i[0];
                    end
                end
                pid_scaling_pkg::OFS_SPD_REF: nxt.spd_ref = merge(st_ff.spd_ref, wb_dat_i, wb_sel_i);
                pid_scaling_pkg::OFS_REF_SRC: begin
                    if (wb_sel_i[0]) begin
                        nxt.ref_src = wb_dat_i[0];
                    end
                end
                pid_scaling_pkg::OFS_IRQ_EN: begin
                    if (wb_sel_i[0]) begin
                        nxt.irq_en = wb_dat_i[pid_scaling_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                    for (int i = 0; i < DN; i++) begin
                        if (wb_adr_i == pid_scaling_pkg::OFS_DO_BASE + 8'(4 * i) && wb_sel_i[0]) begin
                            nxt.do_func[i] = wb_dat_i[7:0];
                        end
                    end
                end
            endcase
        end
        // Mode input is a pin: two flops before anything looks at it
        nxt.sync      = {st_ff.sync[0], auto_mode_i};
        nxt.auto_prev = auto_mode;
        // Bumpless transfer beats a same-cycle software write to the setpoint
        if (load_evt) begin
            nxt.kpad_ref = fb;
        end
        nxt.ms_cnt = ms_tick ? 18'h00000 : st_ff.ms_cnt + 18'h00001;
        if (ms_tick) begin
            nxt.smp_cnt = smp_tick ? 6'h00 : st_ff.smp_cnt + 6'h01;
        end
        if (st_ff.func_sel == pid_scaling_pkg::FS_NONE) begin
            nxt.pid_out = 16'h0000;
            nxt.e_prev  = 17'h00000;
        end else if (smp_tick) begin
            e_cur = longint'(ref_filt) - longint'(fb);
            if (st_ff.action) begin
                e_cur = -e_cur;
            end
            acc = longint'(st_ff.kp) *
                  ((longint'(pid_scaling_pkg::GAIN_ONE) +
                    longint'(pid_scaling_pkg::KI_TA_MUL) * longint'(st_ff.ki) +
                    longint'(pid_scaling_pkg::KD_TA_MUL) * longint'(st_ff.kd)) * e_cur -
                   longint'(pid_scaling_pkg::KD_TA_MUL) * longint'(st_ff.kd) *
                   longint'(signed'(st_ff.e_prev))) / longint'(pid_scaling_pkg::GAIN_DIV);
            y_new = longint'(st_ff.pid_out) + acc;
            if (y_new < 0) begin
                y_new = 0;
            end else if (y_new > longint'(pid_scaling_pkg::PCT_FULL)) begin
                y_new = longint'(pid_scaling_pkg::PCT_FULL);
            end
            nxt.pid_out = 16'(y_new);
            nxt.e_prev  = 17'(e_cur);
        end
        // Manual mode drives the motor from the keypad speed reference
        nxt.spd_out = (auto_mode && pid_enable_o) ? st_ff.pid_out : st_ff.spd_ref;
        nxt.fb_ind  = scale_ind(fb, st_ff.scale);
        nxt.ref_ind = scale_ind(ref_filt, st_ff.scale);
        for (int i = 0; i < DN; i++) begin
            nxt.do_out[i] = compare_out(st_ff.do_func[i], fb, st_ff.thr);
        end
        nxt.above = fb_above;
        ev[pid_scaling_pkg::IRQ_SAMPLE] = smp_tick;
        ev[pid_scaling_pkg::IRQ_LOAD]   = load_evt;
        ev[pid_scaling_pkg::IRQ_CROSS]  = fb_above & ~st_ff.above;
        nxt.irq_st = (st_ff.irq_st & ~clr) | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff          <= '0;
            st_ff.filt_ms  <= pid_scaling_pkg::FILT_RST;
            st_ff.scale    <= pid_scaling_pkg::SCALE_RST;
            st_ff.fmt      <= pid_scaling_pkg::FMT_RST;
            st_ff.thr      <= pid_scaling_pkg::THR_RST;
            // Reset stands in for power loss; the backed-up setpoint survives it
            if (st_ff.load_en) begin
                st_ff.kpad_ref <= st_ff.kpad_ref;
                st_ff.load_en  <= 1'b1;
            end
        end else begin
            st_ff <= nxt;
        end
    end

    assign wb_ack_o          = st_ff.ack;
    assign wb_dat_o          = st_ff.rdat;
    assign pid_enable_o      = st_ff.func_sel != pid_scaling_pkg::FS_NONE;
    assign pid_output_o      = st_ff.pid_out;
    assign speed_reference_o = st_ff.spd_out;
    assign digital_outputs_o = st_ff.do_out;
    assign irq_o             = |(st_ff.irq_st & st_ff.irq_en);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in one cycle");
    a_pid_disable: assert property (st_ff.func_sel == pid_scaling_pkg::FS_NONE |=>
        pid_output_o == 16'h0000) else $error("disabled PID left output");
    a_fb_scale_full: assert property (fb == 16'h03E8 |=> st_ff.fb_ind == $past(st_ff.scale))
        else $error("full feedback not shown as scale");
    a_ref_scale: assert property (1'b1 |=> st_ff.ref_ind == scale_ind($past(ref_filt),
        $past(st_ff.scale))) else $error("reference indication mis-scaled");
    a_manual_speed: assert property (!auto_mode |=> speed_reference_o == $past(st_ff.spd_ref))
        else $error("manual speed reference not used");
    a_do_above: assert property (st_ff.do_func[0] == pid_scaling_pkg::DO_ABOVE && fb_above
        |=> digital_outputs_o[0]) else $error("above-threshold output missing");
    a_do_below: assert property (st_ff.do_func[0] == pid_scaling_pkg::DO_BELOW &&
        fb >= st_ff.thr |=> !digital_outputs_o[0]) else $error("below output wrong");
    a_auto_load: assert property (load_evt |=> st_ff.kpad_ref == $past(fb) &&
        st_ff.irq_st[pid_scaling_pkg::IRQ_LOAD]) else $error("setpoint not loaded");
    a_sample_gap: assert property (smp_tick |=> !smp_tick [*8])
        else $error("sample ticks too close");
    a_irq_set_wins: assert property (|ev |=> (st_ff.irq_st & $past(ev)) == $past(ev))
        else $error("interrupt event lost");

    c_auto_load: cover property (load_evt);
    c_sample: cover property (smp_tick && pid_enable_o);
    c_irq: cover property (irq_o);
    c_reverse: cover property (smp_tick && st_ff.action);
endmodule // pid_setpoint_feedback_scaling
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the PID setpoint and scaling block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        auto_mode_i, pid_enable_o, irq_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_q;
    logic [15:0] pv, ai1, ai3, fi, speed_reference_o, pid_output_o;
    logic [4:0]  digital_outputs_o;
    int          n_errors, num_checks;

    pid_setpoint_feedback_scaling #(.MS_CYCLES(20), .SAMPLE_MS(3)) i_pid_setpoint_feedback_scaling (
        .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
        .wb_dat_o, .wb_ack_o, .first_analog_input_i(ai1), .third_analog_input_i(ai3),
        .frequency_input_i(fi), .external_reference_i(16'h0000), .auto_mode_i,
        .pid_enable_o, .pid_output_o, .speed_reference_o, .digital_outputs_o, .irq_o);
    xducer_model i_xducer_model (.clk_i, .pv_i(pv), .ai1_o(ai1), .ai3_o(ai3), .fi_o(fi));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) n_errors++;
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        // Keep the strobe low for a full cycle between transfers
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd_q, e);
    endtask

    task automatic t_defaults;
        rdc(pid_scaling_pkg::OFS_FILT, 32'h0000_0032);
        rdc(pid_scaling_pkg::OFS_ACTION, 32'h0000_0000);
        rdc(pid_scaling_pkg::OFS_SCALE, 32'h0000_03E8);
        rdc(pid_scaling_pkg::OFS_FMT, 32'h0000_0001);
        rdc(pid_scaling_pkg::OFS_THR, 32'h0000_0384);
        rdc(pid_scaling_pkg::OFS_KD, 32'h0000_0000);
        rdc(8'hFC, 32'h0000_0000);
    endtask

    task automatic t_select;
        wr(pid_scaling_pkg::OFS_SCALE, 32'h0000_00FA);
        wr(pid_scaling_pkg::OFS_FMT, 32'h0000_0002);
        wr(pid_scaling_pkg::OFS_FB_IND, 32'h0000_FFFF);
        for (int f = 0; f < 4; f++) begin
            wr(pid_scaling_pkg::OFS_FUNC, 32'(f));
            repeat (3) @(posedge clk_i);
            chk(32'(pid_enable_o), 32'(f != 0));
            // Indication is feedback times scale over 1000, format code on top
            if (f != 0) rdc(pid_scaling_pkg::OFS_FB_IND, 32'h0002_0000 | ((32'h12C + 32'h11 * 32'(f - 1)) * 32'hFA / 32'h3E8));
        end
    endtask

    task automatic t_threshold;
        wr(pid_scaling_pkg::OFS_DO_BASE, 32'h0000_0016);
        wr(pid_scaling_pkg::OFS_DO_BASE + 8'h04, 32'h0000_0017);
        wr(pid_scaling_pkg::OFS_THR, 32'h0000_01F4);
        wr(pid_scaling_pkg::OFS_IRQ_EN, 32'h0000_0004);
        pv <= 16'h0190;
        repeat (4) @(posedge clk_i);
        chk(32'(digital_outputs_o), 32'h0000_0002);
        pv <= 16'h0258;
        repeat (4) @(posedge clk_i);
        chk(32'(digital_outputs_o), 32'h0000_0001);
        chk(32'(irq_o), 32'h0000_0001);
        wr(pid_scaling_pkg::OFS_IRQ_EN, 32'h0000_0000);
        chk(32'(irq_o), 32'h0000_0000);
        wr(pid_scaling_pkg::OFS_IRQ_EN, 32'h0000_0004);
        chk(32'(irq_o), 32'h0000_0001);
        wr(pid_scaling_pkg::OFS_IRQ_CLR, 32'h0000_0004);
        chk(32'(irq_o), 32'h0000_0000);
    endtask

    task automatic t_autoload;
        wr(pid_scaling_pkg::OFS_LOAD_EN, 32'h0000_0001);
        wr(pid_scaling_pkg::OFS_FILT, 32'h0000_0000);
        auto_mode_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdc(pid_scaling_pkg::OFS_KPAD_REF, 32'h0000_027A);
        repeat (50) @(posedge clk_i);
        rdc(pid_scaling_pkg::OFS_REF_IND, 32'h0002_009E);
    endtask

    task automatic t_manual;
        auto_mode_i <= 1'b0;
        wr(pid_scaling_pkg::OFS_SPD_REF, 32'h0000_0123);
        repeat (6) @(posedge clk_i);
        chk(32'(speed_reference_o), 32'h0000_0123);
        // All gains still zero, so the recursion never leaves its reset value
        chk(32'(pid_output_o), 32'h0000_0000);
    endtask

    task automatic t_retain;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(pid_scaling_pkg::OFS_KPAD_REF, 32'h0000_027A);
        rdc(pid_scaling_pkg::OFS_LOAD_EN, 32'h0000_0001);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        stop_test();
    end

    initial begin
        n_errors = 0;
        num_checks = 0;
        {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, auto_mode_i} = 5'b10000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        pv = 16'h012C;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_defaults();
        t_select();
        t_threshold();
        t_autoload();
        t_manual();
        t_retain();
        stop_test();
    end
endmodule // tb
`default_nettype wire

// [test/xducer_model.sv]
// Process transducer model driving the three feedback inputs
`timescale 1ns/1ps
`default_nettype none
module xducer_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] pv_i,
    output logic      [15:0] ai1_o,
    output logic      [15:0] ai3_o,
    output logic      [15:0] fi_o
);
    // Distinct offsets per input, so a wrong source selection shows up
    always_ff @(posedge clk_i) begin
        ai1_o <= pv_i;
        ai3_o <= pv_i + 16'h0011;
        fi_o  <= pv_i + 16'h0022;
    end
endmodule // xducer_model
`default_nettype wire
